/* File: hdl/sipl_pkg.sv */
// constants, types and register map of the interrupt pin logic
package sipl_pkg;

  // clock and timing
  localparam int CLK_KHZ      = 25000;
  localparam int TIMEOUT_US   = 6000;
  localparam int PULSE_NS     = 10000;
  // longest low time rounds down, least pulse width rounds up
  localparam int TIMEOUT_CYC  = (TIMEOUT_US * CLK_KHZ) / 1000;
  localparam int PULSE_CYC    = (PULSE_NS * CLK_KHZ + 999999) / 1000000;
  localparam int CNT_W        = 18;

  // register indexes, byte address is four times the index
  localparam logic [3:0] IDX_SUMMARY = 4'h0;
  localparam logic [3:0] IDX_REGFLG  = 4'h1;
  localparam logic [3:0] IDX_EVFLG   = 4'h2;
  localparam logic [3:0] IDX_MASK    = 4'h3;
  localparam logic [3:0] IDX_CTRL    = 4'h4;
  localparam logic [3:0] IDX_ISTAT   = 4'h5;
  localparam logic [3:0] IDX_ICLR    = 4'h6;
  localparam logic [3:0] IDX_IEN     = 4'h7;
  localparam logic [3:0] IDX_PIN     = 4'h8;

  // summary register fields
  localparam int SUM_INT_BIT  = 0;
  localparam int SUM_WAKE_BIT = 1;
  // regulator flag register fields
  localparam int RF_UV_A_BIT  = 0;
  localparam int RF_UV_B_BIT  = 1;
  localparam int RF_OT_A_BIT  = 2;
  // control register fields
  localparam int CT_EN_A_BIT  = 0;
  localparam int CT_EN_B_BIT  = 1;
  // interrupt source index inside the mask
  localparam int SRC_WAKE     = 0;
  localparam int SRC_UV_A     = 1;
  localparam int SRC_UV_B     = 2;
  localparam int SRC_OT_A     = 3;
  localparam int SRC_EV0      = 4;
  localparam int NUM_SRC      = 8;
  localparam int NUM_EV       = 4;
  // sticky status fields
  localparam int IS_ACT_BIT   = 0;
  localparam int IS_TMO_BIT   = 1;
  localparam int IS_HELD_BIT  = 2;
  localparam int NUM_IS       = 3;

  // reset values
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [2:0] IEN_RST  = 3'h0;

  // operating mode of the basis chip
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_STOP,
    MODE_RESTART,
    MODE_OTHER
  } sipl_mode_t;

  // classic wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } sipl_wb_req_t;

  // wishbone answer
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } sipl_wb_rsp_t;

endpackage

/* File: hdl/sipl_top.sv */
// interrupt pin logic of the basis chip with a wishbone register file
//
// Overview of operation
// - switching on a regulator sets its undervoltage flag and raises interrupt
// - read before threshold is crossed leaves the undervoltage flag set
// - leaving undervoltage later raises a second interrupt
// - switch-on interrupt fires on flag rising only
// - undervoltage interrupts on appear and disappear; flag shows live state
// - overtemperature interrupts on appear only; flag shows live state
// - interrupt pin goes low at once unless the gap holds it off
// - read-only access to register 000 releases the interrupt pin
// - several sources before the read give one low pulse
// - pin low at most the time-out, flags keep the source
// - at least one time-out between activations while the mode stays normal or stop, later events are held
// - each low pulse lasts at least 10 us unless normal or stop mode is left during it
// - interrupts work only in normal or stop mode
// - all sources enabled at reset and after every restart
// - read clears both flags, held second pulse still occurs
// - masked source sets its flag but does not drive the pin
// - summary bit set while any flag of registers 001 and 010 is set
// - state flags latch until read, event flags clear on read
//
// limitations and trade-offs:
// - one counter runs from activation through the gap, so the gap is
//   measured from the start of a pulse, not from its release
// - an event that lands while the pin is held low after the release read
//   is kept for the next pulse, as the host has already read its flags
// - a switch-on pulse needs the flag to be clear, so switching a regulator
//   off and on again while its flag is still set stays silent
// - comparator edges are seen two cycles late through the synchroniser
// - leaving normal or stop mode drops a held event; its flag remains
`timescale 1ns/1ps
module sipl_top
  import sipl_pkg::*;
#(
  parameter int TIMEOUT = TIMEOUT_CYC  // time-out in clock cycles
) (
  input  wire logic                 clk_i,    // 25 MHz clock
  input  wire logic                 rst_i,    // synchronous reset
  input  wire logic                 ce_i,     // clock enable
  input  wire sipl_pkg::sipl_wb_req_t wb_i,   // wishbone request
  output sipl_pkg::sipl_wb_rsp_t    wb_o,     // wishbone answer
  input  wire sipl_pkg::sipl_mode_t mode_i,   // chip operating mode
  input  wire logic                 uv_a_i,   // regulator a undervoltage
  input  wire logic                 uv_b_i,   // regulator b undervoltage
  input  wire logic                 ot_a_i,   // regulator a overtemp
  input  wire logic                 wake_i,   // wake event pulse
  input  wire logic [3:0]           ev_i,     // other event pulses
  output logic                      aux_regulator_a_en_o, // reg a on
  output logic                      aux_regulator_b_en_o, // reg b on
  output logic                      int_n_o,  // interrupt pin, low active
  output logic                      irq_o     // level interrupt
);

  import sipl_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_GAP} sipl_state_t;

  localparam logic [CNT_W-1:0] TMO_LAST   = CNT_W'(TIMEOUT - 1);
  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC - 1);

  sipl_state_t         state;
  logic [CNT_W-1:0]    cnt;
  logic                pending;
  logic                rel_req;
  logic [2:0]          sync1;
  logic [2:0]          sync2;
  logic [2:0]          live_d;
  logic                reg2_undervolt_flag;
  logic                reg3_undervolt_flag;
  logic                reg2_overtemp_flag;
  logic                wake_flag;
  logic [NUM_EV-1:0]   ev_flag;
  logic [7:0]          mask;
  logic [1:0]          ctrl;
  logic [NUM_IS-1:0]   istat;
  logic [NUM_IS-1:0]   ien;
  logic [NUM_SRC-1:0]  src;
  logic                active;
  logic                trig;
  logic                int_sum;
  logic                acc;
  logic                rd_sum;
  logic                rd_reg;
  logic                rd_ev;
  logic                wr_lane;
  logic [1:0]          next_ctrl;
  logic [1:0]          sw_on;
  logic                uv_a;
  logic                uv_b;
  logic                ot_a;
  logic                go_low;
  logic                tmo_hit;
  logic                early_rel;
  logic                hold_evt;
  logic [NUM_IS-1:0]   is_evt;
  logic [31:0]         rdata;

  //////////////////////////////////////////////////////////////////////////
  // comparator inputs come from the analog side, two flops each

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1  <= 3'h0;
      sync2  <= 3'h0;
      live_d <= 3'h0;
    end else if (ce_i) begin
      sync1  <= {ot_a_i, uv_b_i, uv_a_i};
      sync2  <= sync1;
      live_d <= sync2;
    end
  end

  // undervoltage while a regulator is off is expected, so it is ignored
  assign uv_a = sync2[0] & ctrl[CT_EN_A_BIT];
  assign uv_b = sync2[1] & ctrl[CT_EN_B_BIT];
  assign ot_a = sync2[2];

  //////////////////////////////////////////////////////////////////////////
  // bus access decode, side effects happen in the request cycle, one cycle before the ack

  assign acc     = wb_i.cyc & wb_i.stb & ~wb_o.ack;
  assign wr_lane = acc & wb_i.we & wb_i.sel[0];
  assign rd_sum  = acc & ~wb_i.we & (wb_i.adr[5:2] == IDX_SUMMARY);
  assign rd_reg  = acc & ~wb_i.we & (wb_i.adr[5:2] == IDX_REGFLG);
  assign rd_ev   = acc & ~wb_i.we & (wb_i.adr[5:2] == IDX_EVFLG);

  always_comb begin
    next_ctrl = ctrl;
    if (wr_lane && wb_i.adr[5:2] == IDX_CTRL) begin
      next_ctrl = wb_i.dat[1:0];
    end
  end

  // a rising control bit is the switch-on command
  assign sw_on = next_ctrl & ~ctrl;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RST;
    end else if (ce_i) begin
      ctrl <= next_ctrl;
    end
  end

  assign aux_regulator_a_en_o = ctrl[CT_EN_A_BIT];
  assign aux_regulator_b_en_o = ctrl[CT_EN_B_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask <= MASK_RST;
    end else if (ce_i) begin
      // restart holds the mask at all ones for as long as it lasts
      if (mode_i == MODE_RESTART) begin
        mask <= MASK_RST;
      end else if (wr_lane && wb_i.adr[5:2] == IDX_MASK) begin
        mask <= wb_i.dat[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // source flags: live state or'ed in, so a read cannot clear a present
  // failure; a new event in the read cycle wins over the clear

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg2_undervolt_flag <= 1'b0;
      reg3_undervolt_flag <= 1'b0;
      reg2_overtemp_flag  <= 1'b0;
    end else if (ce_i) begin
      reg2_undervolt_flag <= (reg2_undervolt_flag & ~rd_reg)
                             | sw_on[0] | uv_a;
      reg3_undervolt_flag <= (reg3_undervolt_flag & ~rd_reg)
                             | sw_on[1] | uv_b;
      reg2_overtemp_flag  <= (reg2_overtemp_flag & ~rd_reg)
                             | ot_a;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_flag <= 1'b0;
      ev_flag   <= '0;
    end else if (ce_i) begin
      wake_flag <= (wake_flag & ~rd_sum) | wake_i;
      ev_flag   <= (ev_flag & ~{NUM_EV{rd_ev}}) | ev_i;
    end
  end

  // wake has its own bit and stays out of the summary
  assign int_sum = reg2_undervolt_flag | reg3_undervolt_flag
                   | reg2_overtemp_flag | (|ev_flag);

  //////////////////////////////////////////////////////////////////////////
  // interrupt triggers per source; mask gates the pin, never the flag

  assign src[SRC_WAKE] = wake_i;
  assign src[SRC_UV_A] = (sw_on[0] & ~reg2_undervolt_flag)
                         | (sync2[0] != live_d[0])
                           & ctrl[CT_EN_A_BIT];
  assign src[SRC_UV_B] = (sw_on[1] & ~reg3_undervolt_flag)
                         | (sync2[1] != live_d[1])
                           & ctrl[CT_EN_B_BIT];
  assign src[SRC_OT_A] = ot_a & ~live_d[2];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EV; gi++) begin : g_ev
      assign src[SRC_EV0 + gi] = ev_i[gi];
    end
  endgenerate

  assign active = (mode_i == MODE_NORMAL) | (mode_i == MODE_STOP);
  assign trig   = active & (|(src & mask));

  //////////////////////////////////////////////////////////////////////////
  // pin sequencer: the counter runs from activation through the gap, so
  // one counter serves pulse width, time-out and spacing
  // a time-out goes straight back to idle: a full time-out has passed
  // since activation, so the spacing rule is already met

  assign go_low    = (state == ST_IDLE) & (pending | trig);
  assign tmo_hit   = (cnt == TMO_LAST);
  assign early_rel = rel_req & (cnt >= PULSE_LAST);
  // an event after the release read belongs to the next pulse, since the
  // host has already fetched the flags that this pulse announced
  assign hold_evt  = (state == ST_GAP)
                     | ((state == ST_LOW) & (rel_req | rd_sum));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cnt   <= '0;
    end else if (ce_i) begin
      if (!active) begin
        state <= ST_IDLE;
        cnt   <= '0;
      end else begin
        case (state)
          ST_IDLE: begin
            cnt <= '0;
            if (go_low) begin
              state <= ST_LOW;
            end
          end
          ST_LOW: begin
            cnt <= cnt + CNT_W'(1);
            if (tmo_hit) begin
              state <= ST_IDLE;
            end else if (early_rel) begin
              state <= ST_GAP;
            end
          end
          ST_GAP: begin
            cnt <= cnt + CNT_W'(1);
            if (tmo_hit) begin
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_IDLE;
            cnt   <= '0;
          end
        endcase
      end
    end
  end

  // events before the release read merge into the pulse; later ones wait
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending <= 1'b0;
    end else if (ce_i) begin
      if (!active || go_low) begin
        pending <= 1'b0;
      end else if (trig && hold_evt) begin
        pending <= 1'b1;
      end
    end
  end

  // release request is remembered so an early read still gets a full pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rel_req <= 1'b0;
    end else if (ce_i) begin
      if (state != ST_LOW) begin
        rel_req <= 1'b0;
      end else if (rd_sum) begin
        rel_req <= 1'b1;
      end
    end
  end

  assign int_n_o = (state != ST_LOW);

  //////////////////////////////////////////////////////////////////////////
  // sticky status, write-one clear, enable gating onto irq_o
  // an event in the cycle of a clear write wins, so none is lost

  assign is_evt[IS_ACT_BIT]  = ce_i & active & go_low;
  assign is_evt[IS_TMO_BIT]  = ce_i & active & (state == ST_LOW) & tmo_hit;
  assign is_evt[IS_HELD_BIT] = ce_i & trig & hold_evt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      istat <= '0;
      ien   <= IEN_RST;
    end else if (ce_i) begin
      if (wr_lane && wb_i.adr[5:2] == IDX_ICLR) begin
        istat <= (istat & ~wb_i.dat[NUM_IS-1:0]) | is_evt;
      end else begin
        istat <= istat | is_evt;
      end
      if (wr_lane && wb_i.adr[5:2] == IDX_IEN) begin
        ien <= wb_i.dat[NUM_IS-1:0];
      end
    end
  end

  assign irq_o = |(istat & ien);

  //////////////////////////////////////////////////////////////////////////
  // read mux and acknowledge, unmapped reads return zero

  always_comb begin
    rdata = 32'h0;
    case (wb_i.adr[5:2])
      IDX_SUMMARY: begin
        rdata[SUM_INT_BIT]  = int_sum;
        rdata[SUM_WAKE_BIT] = wake_flag;
      end
      IDX_REGFLG: begin
        rdata[RF_UV_A_BIT] = reg2_undervolt_flag;
        rdata[RF_UV_B_BIT] = reg3_undervolt_flag;
        rdata[RF_OT_A_BIT] = reg2_overtemp_flag;
      end
      IDX_EVFLG: begin
        rdata[NUM_EV-1:0] = ev_flag;
      end
      IDX_MASK: begin
        rdata[7:0] = mask;
      end
      IDX_CTRL: begin
        rdata[1:0] = ctrl;
      end
      IDX_ISTAT: begin
        rdata[NUM_IS-1:0] = istat;
      end
      IDX_IEN: begin
        rdata[NUM_IS-1:0] = ien;
      end
      IDX_PIN: begin
        rdata[1:0] = {pending, ~int_n_o};
      end
      default:   rdata = 32'h0;
    endcase
  end

  // ack is registered: every access takes one wait state and its side
  // effects land on the edge that takes the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_o <= '0;
    end else if (ce_i) begin
      wb_o.ack <= acc;
      if (acc && !wb_i.we) begin
        wb_o.dat <= rdata;
      end
    end
  end

endmodule

/* File: test/sipl_top_sva.sv */
// assertion checker for the interrupt pin logic
`timescale 1ns/1ps
module sipl_top_sva
  import sipl_pkg::*;
#(
  parameter int TIMEOUT = TIMEOUT_CYC  // time-out in cycles
) (
  input wire logic                   clk_i,   // clock
  input wire logic                   rst_i,   // reset
  input wire logic                   ce_i,    // clock enable
  input wire sipl_pkg::sipl_wb_req_t wb_i,    // bus request
  input wire sipl_pkg::sipl_wb_rsp_t wb_o,    // bus answer
  input wire sipl_pkg::sipl_mode_t   mode_i,  // chip mode
  input wire logic                   int_n_o  // interrupt pin
);
  localparam int PULSE = PULSE_CYC;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic act;
  int   lo_cnt;
  int   gap_cnt;
  assign act = mode_i == MODE_NORMAL || mode_i == MODE_STOP;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i || int_n_o) lo_cnt <= 0;
    else lo_cnt <= lo_cnt + 1;
  end
  // disabled modes clear the design's gap timer, so set ours to a full time-out, as if the gap had elapsed
  always_ff @(posedge clk_i) begin
    if (rst_i || !act) gap_cnt <= TIMEOUT;
    else if ($fell(int_n_o)) gap_cnt <= 1;
    else if (gap_cnt < TIMEOUT) gap_cnt <= gap_cnt + 1;
  end
  ////////////////////////////////////////////////////////////
  sequence s_req;
    wb_i.cyc && wb_i.stb && !wb_o.ack && ce_i;
  endsequence
  sequence s_ans;
    wb_o.ack ##1 !wb_o.ack;
  endsequence
  property p_ack;
    s_req |=> s_ans;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
  property p_ack_cause;
    wb_o.ack |-> $past(wb_i.cyc && wb_i.stb);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_rel;
    wb_o.ack && !wb_i.we && wb_i.adr[5:2] == IDX_SUMMARY && !int_n_o
      && act && lo_cnt >= PULSE |-> ##[0:2] int_n_o;
  endproperty
  a_rel: assert property (p_rel) else $error("pin not released");
  property p_fall_mode;
    $fell(int_n_o) |-> $past(act);
  endproperty
  a_fall_mode: assert property (p_fall_mode)
    else $error("pin low in idle mode");
  property p_mode;
    !act |=> int_n_o;
  endproperty
  a_mode: assert property (p_mode) else $error("pin low off mode");
  property p_min;
    $rose(int_n_o) && act && $past(act) |-> lo_cnt >= PULSE;
  endproperty
  a_min: assert property (p_min) else $error("pulse too short");
  property p_max;
    lo_cnt <= TIMEOUT;
  endproperty
  a_max: assert property (p_max) else $error("pulse too long");
  property p_gap;
    $fell(int_n_o) |-> gap_cnt >= TIMEOUT;
  endproperty
  a_gap: assert property (p_gap) else $error("pulses too close");
endmodule
bind sipl_top sipl_top_sva #(.TIMEOUT(TIMEOUT)) sipl_top_sva_i (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_i(wb_i), .wb_o(wb_o),
  .mode_i(mode_i), .int_n_o(int_n_o));

/* File: test/sipl_reg_model.sv */
// regulator output model: undervoltage until the ramp completes
`timescale 1ns/1ps
module sipl_reg_model #(
  parameter int RAMP = 300  // cycles from enable to good output
) (
  input  wire logic clk_i,  // clock
  input  wire logic rst_i,  // reset
  input  wire logic en_i,   // regulator enabled
  output logic      uv_o    // undervoltage, high = failure
);
  int cnt;
  // a disabled regulator reads as undervoltage, like a real output
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) cnt <= 0;
    else if (cnt < RAMP) cnt <= cnt + 1;
  end
  assign uv_o = !en_i || cnt < RAMP;
endmodule

/* File: test/sipl_top_test.sv */
// self-checking bench of the interrupt pin logic
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module sipl_top_test;
  import sipl_pkg::*;
  localparam int TMO = 400;
  sipl_wb_req_t wb_i;
  sipl_wb_rsp_t wb_o;
  sipl_mode_t   mode_i;
  logic         clk_i, rst_i, uv_a, ot_a_i, wake_i, en_a, en_b, int_n_o,
                irq_o;
  logic [3:0]   ev_i;
  logic [31:0]  rd;
  int           fails, num_checks, cyc_cnt;
  sipl_top #(.TIMEOUT(TMO)) sipl_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_i(wb_i), .wb_o(wb_o),
    .mode_i(mode_i), .uv_a_i(uv_a), .uv_b_i(1'b1), .ot_a_i(ot_a_i),
    .wake_i(wake_i), .ev_i(ev_i), .aux_regulator_a_en_o(en_a),
    .aux_regulator_b_en_o(en_b), .int_n_o(int_n_o), .irq_o(irq_o));
  sipl_reg_model #(.RAMP(300)) sipl_reg_model_i (
    .clk_i(clk_i), .rst_i(rst_i), .en_i(en_a), .uv_o(uv_a));
  ////////////////////////////////////////////////////////////
  initial begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic acc(input logic w, input logic [3:0] i,
                     input logic [31:0] d);
    // no cycle count assumed: only the bench timeout ends this wait
    wb_i <= '{1'b1, 1'b1, w, {i, 2'b00}, 4'hF, d};
    do begin
      @(posedge clk_i);
    end while (wb_o.ack !== 1'b1);
    rd = wb_o.dat;
    wb_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic wait_pin(input logic v, input int m);
    int n;
    n = 0;
    while (int_n_o !== v && n < m) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(int_n_o, v)
  endtask
  task automatic ev_pulse(input logic [3:0] e);
    ev_i <= e;
    @(posedge clk_i);
    ev_i <= 4'h0;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {rst_i, ot_a_i, wake_i, ev_i, fails, num_checks} = '0;
    rst_i = 1;
    wb_i = '0;
    mode_i = MODE_NORMAL;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    acc(0, IDX_MASK, 0);
    `CHK(rd, 32'hFF)
    acc(0, 4'h9, 0);
    `CHK(rd, 32'h0)
    acc(1, IDX_CTRL, 32'h1);
    `CHK(en_a, 1'b1)
    wait_pin(0, 5);
    acc(0, IDX_REGFLG, 0);
    `CHK(rd[0], 1'b1)
    acc(0, IDX_REGFLG, 0);
    `CHK(rd[0], 1'b1)
    acc(0, IDX_SUMMARY, 0);
    `CHK(rd[0], 1'b1)
    wait_pin(1, 300);
    wait_pin(0, 300);
    acc(0, IDX_REGFLG, 0);
    acc(0, IDX_REGFLG, 0);
    `CHK(rd[0], 1'b0)
    // read once the least width has passed: release follows the access
    repeat (260) @(posedge clk_i);
    acc(0, IDX_SUMMARY, 0);
    wait_pin(1, 3);
    // second source while the pin is low joins the same pulse
    ev_pulse(4'h1);
    wait_pin(0, 500);
    ev_pulse(4'h2);
    acc(0, IDX_EVFLG, 0);
    `CHK(rd, 32'h3)
    acc(0, IDX_EVFLG, 0);
    `CHK(rd, 32'h0)
    acc(0, IDX_SUMMARY, 0);
    wait_pin(1, 300);
    repeat (450) @(posedge clk_i);
    `CHK(int_n_o, 1'b1)
    acc(1, IDX_MASK, 32'hEF);
    ev_pulse(4'h1);
    repeat (5) @(posedge clk_i);
    `CHK(int_n_o, 1'b1)
    acc(0, IDX_EVFLG, 0);
    `CHK(rd, 32'h1)
    mode_i <= MODE_RESTART;
    @(posedge clk_i);
    mode_i <= MODE_NORMAL;
    acc(0, IDX_MASK, 0);
    `CHK(rd, 32'hFF)
    // second event in the gap, both read before it fires: pulse still comes
    ev_pulse(4'h1);
    wait_pin(0, 5);
    acc(0, IDX_SUMMARY, 0);
    wait_pin(1, 300);
    ev_pulse(4'h2);
    acc(0, IDX_EVFLG, 0);
    `CHK(rd, 32'h3)
    wait_pin(0, 200);
    acc(0, IDX_EVFLG, 0);
    `CHK(rd, 32'h0)
    acc(0, IDX_SUMMARY, 0);
    `CHK(rd, 32'h0)
    wait_pin(1, 300);
    repeat (200) @(posedge clk_i);
    // no read: only the time-out lets the pin go
    ot_a_i <= 1;
    wait_pin(0, 20);
    wait_pin(1, TMO + 10);
    acc(0, IDX_REGFLG, 0);
    `CHK(rd[2], 1'b1)
    acc(0, IDX_ISTAT, 0);
    `CHK(rd, 32'h7)
    acc(1, IDX_IEN, 32'h2);
    `CHK(irq_o, 1'b1)
    acc(1, IDX_IEN, 32'h0);
    `CHK(irq_o, 1'b0)
    acc(1, IDX_IEN, 32'h2);
    acc(1, IDX_ICLR, 32'h2);
    `CHK(irq_o, 1'b0)
    ot_a_i <= 0;
    repeat (450) @(posedge clk_i);
    `CHK(int_n_o, 1'b1)
    // regulator b output is shorted: its flag can never be read clear
    acc(1, IDX_CTRL, 32'h3);
    `CHK(en_b, 1'b1)
    wait_pin(0, 5);
    acc(0, IDX_REGFLG, 0);
    acc(0, IDX_REGFLG, 0);
    `CHK(rd[1], 1'b1)
    acc(0, IDX_SUMMARY, 0);
    wait_pin(1, 300);
    mode_i <= MODE_OTHER;
    @(posedge clk_i);
    wake_i <= 1;
    @(posedge clk_i);
    wake_i <= 0;
    repeat (5) @(posedge clk_i);
    `CHK(int_n_o, 1'b1)
    mode_i <= MODE_NORMAL;
    repeat (5) @(posedge clk_i);
    `CHK(int_n_o, 1'b1)
    acc(0, IDX_SUMMARY, 0);
    `CHK(rd[1], 1'b1)
    acc(0, IDX_SUMMARY, 0);
    `CHK(rd[1], 1'b0)
    summarize();
  end
endmodule
